// file: stgm_defines.svh
// register offsets, reset values and field positions for the serial/timer port mux
`ifndef STGM_DEFINES_SVH
`define STGM_DEFINES_SVH
`define STGM_ADDR_SER_DATA 8'h24
`define STGM_ADDR_SER_DIR 8'h26
`define STGM_ADDR_SER_FUNC 8'h27
`define STGM_ADDR_TMR_DATA 8'h28
`define STGM_ADDR_TMR_DIR 8'h2a
`define STGM_ADDR_TMR_FUNC 8'h2b
`define STGM_ADDR_ODE 8'h2c
`define STGM_RST_SER_LATCH 8'hff
`define STGM_RST_SER_DIR 8'hc0
`define STGM_RST_SER_FUNC 8'h00
`define STGM_RST_TMR_LATCH 4'hf
`define STGM_RST_TMR_DIR 4'h0
`define STGM_RST_TMR_FUNC 4'h0
`define STGM_RST_ODE 8'h00
`define STGM_RST_SER_SYNC 8'hff
`define STGM_RST_TMR_SYNC 4'hf
`define STGM_ODE_TX0_BIT 3
`define STGM_ODE_TX1_BIT 4
`endif

// file: stgm_pkg.sv
// types for the serial/timer port mux
`default_nettype none
package stgm_pkg;
  typedef logic [7:0] stgm_byte_t;
  typedef logic [3:0] stgm_nib_t;
endpackage
`default_nettype wire

// file: stgm_top.sv
// serial/timer gpio pin-function mux with byte register port
//
// The implementer's own choice: the strobed register port.
`include "stgm_defines.svh"
`default_nettype none
module stgm_top
(
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  // register port
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // serial port pins
  input wire logic [7:0] SER_PIN_IN,
  output logic [7:0] SER_PIN_OUT,
  output logic [7:0] SER_PIN_OE_OUT,
  // timer port pins
  input wire logic [3:0] TMR_PIN_IN,
  output logic [3:0] TMR_PIN_OUT,
  output logic [3:0] TMR_PIN_OE_OUT,
  // serial channel side
  input wire logic SERIAL0_TRANSMIT_IN,
  input wire logic SERIAL1_TRANSMIT_IN,
  input wire logic SERIAL0_CLOCK_PIN_IN,
  input wire logic SERIAL1_CLOCK_PIN_IN,
  output logic SERIAL0_RECEIVE_OUT,
  output logic SERIAL1_RECEIVE_OUT,
  output logic SERIAL0_CLEAR_TO_SEND_OUT,
  output logic SERIAL1_CLEAR_TO_SEND_OUT,
  // timer and interrupt side
  input wire logic TIMER2_COMPARE_OUT0_IN,
  input wire logic TIMER2_COMPARE_OUT1_IN,
  output logic TIMER2_CAPTURE_IN0_OUT,
  output logic TIMER2_CAPTURE_IN1_OUT,
  output logic EXT_IRQ_ONE_OUT,
  output logic EXT_IRQ_TWO_OUT,
  // oscillator connection
  output logic SLOW_OSC_CONNECT_OUT,
  output logic SLOW_OSC_IN_OUT
);
  stgm_pkg::stgm_byte_t ser_latch_q, ser_dir_q, ser_func_q, ode_q;
  stgm_pkg::stgm_nib_t tmr_latch_q, tmr_dir_q, tmr_func_q;
  stgm_pkg::stgm_byte_t rdata_d, rdata_q;
  stgm_pkg::stgm_byte_t ser_out_d, ser_out_q, ser_oe_d, ser_oe_q;
  stgm_pkg::stgm_nib_t tmr_out_d, tmr_out_q, tmr_oe_d, tmr_oe_q;
  logic [9:0] side_d, side_q;
  wire stgm_pkg::stgm_byte_t ser_eff_dir;
  wire stgm_pkg::stgm_byte_t ser_rd;
  wire stgm_pkg::stgm_nib_t tmr_rd;
  wire logic osc_mode;
  wire logic alt0_tx, alt0_clk, alt1_tx, alt1_clk, tcmp0, tcmp1;
  wire logic tx0_val, tx1_val;
  wire logic [7:0] sync_in;
  wire logic [3:0] tsync_in;

  // write decode
  wire logic wr_sdat = WR_IN && (ADDR_IN == `STGM_ADDR_SER_DATA);
  wire logic wr_sdir = WR_IN && (ADDR_IN == `STGM_ADDR_SER_DIR);
  wire logic wr_sfun = WR_IN && (ADDR_IN == `STGM_ADDR_SER_FUNC);
  wire logic wr_tdat = WR_IN && (ADDR_IN == `STGM_ADDR_TMR_DATA);
  wire logic wr_tdir = WR_IN && (ADDR_IN == `STGM_ADDR_TMR_DIR);
  wire logic wr_tfun = WR_IN && (ADDR_IN == `STGM_ADDR_TMR_FUNC);
  wire logic wr_ode = WR_IN && (ADDR_IN == `STGM_ADDR_ODE);

  // alternate output selects
  assign alt0_tx = ser_func_q[0] && ser_dir_q[0];
  assign alt0_clk = ser_func_q[2] && ser_dir_q[2];
  assign alt1_tx = ser_func_q[3] && ser_dir_q[3];
  assign alt1_clk = ser_func_q[5] && ser_dir_q[5];
  assign tcmp0 = tmr_func_q[2] && tmr_dir_q[2];
  assign tcmp1 = tmr_func_q[3] && tmr_dir_q[3];
  // upper pins: function 0 direction 0 hands them to the oscillator
  assign osc_mode = !ser_func_q[6] && !ser_dir_q[6] && !ser_func_q[7] && !ser_dir_q[7];

  assign tx0_val = alt0_tx ? SERIAL0_TRANSMIT_IN : ser_latch_q[0];
  assign tx1_val = alt1_tx ? SERIAL1_TRANSMIT_IN : ser_latch_q[3];

  // reserved combinations are not masked; direction bit alone sets the driver on pins 0 to 5 unless ODE makes pin 0 or 3 open-drain
  assign ser_eff_dir = ser_dir_q;

  always_comb
  begin
    ser_out_d = ser_latch_q;
    ser_oe_d = ser_eff_dir;
    ser_out_d[0] = tx0_val;
    ser_out_d[3] = tx1_val;
    ser_out_d[2] = alt0_clk ? SERIAL0_CLOCK_PIN_IN : ser_latch_q[2];
    ser_out_d[5] = alt1_clk ? SERIAL1_CLOCK_PIN_IN : ser_latch_q[5];
    // open-drain transmit: drive only a low
    if (ode_q[`STGM_ODE_TX0_BIT])
    begin
      ser_oe_d[0] = ser_dir_q[0] && !tx0_val;
    end
    if (ode_q[`STGM_ODE_TX1_BIT])
    begin
      ser_oe_d[3] = ser_dir_q[3] && !tx1_val;
    end
    // upper pins are always open-drain; direction 1 without function is reserved
    ser_out_d[7:6] = 2'h0;
    ser_oe_d[6] = ser_func_q[6] && ser_dir_q[6] && !ser_latch_q[6];
    ser_oe_d[7] = ser_func_q[7] && ser_dir_q[7] && !ser_latch_q[7];
  end

  always_comb
  begin
    tmr_out_d = tmr_latch_q;
    tmr_oe_d = tmr_dir_q;
    tmr_out_d[2] = tcmp0 ? TIMER2_COMPARE_OUT0_IN : tmr_latch_q[2];
    tmr_out_d[3] = tcmp1 ? TIMER2_COMPARE_OUT1_IN : tmr_latch_q[3];
  end

  // peripheral-facing side signals
  always_comb
  begin
    side_d[0] = sync_in[1];
    side_d[1] = sync_in[4];
    side_d[2] = sync_in[2];
    side_d[3] = sync_in[5];
    side_d[4] = tmr_func_q[0] && !tmr_dir_q[0] && tsync_in[0];
    side_d[5] = tmr_func_q[1] && !tmr_dir_q[1] && tsync_in[1];
    side_d[6] = tmr_func_q[0] && !tmr_dir_q[0] && tsync_in[0];
    side_d[7] = tmr_func_q[1] && !tmr_dir_q[1] && tsync_in[1];
    side_d[8] = osc_mode;
    side_d[9] = osc_mode && sync_in[6];
  end

  // input bits read the pin, output bits the driven latch
  assign ser_rd = (ser_dir_q & ser_latch_q) | (~ser_dir_q & sync_in);
  assign tmr_rd = (tmr_dir_q & tmr_latch_q) | (~tmr_dir_q & tsync_in);

  // write-only registers read as zero, so read-modify-write corrupts them
  always_comb
  begin
    rdata_d = 8'h00;
    if (RD_IN && ADDR_IN == `STGM_ADDR_SER_DATA)
    begin
      rdata_d = ser_rd;
    end
    else if (RD_IN && ADDR_IN == `STGM_ADDR_TMR_DATA)
    begin
      rdata_d = {4'h0, tmr_rd};
    end
    else if (RD_IN && ADDR_IN == `STGM_ADDR_ODE)
    begin
      rdata_d = ode_q;
    end
  end

  // pin synchronisers
  stgm_sync2 #(.WIDTH(8), .RESET_VALUE(`STGM_RST_SER_SYNC)) ser_sync_u
  (
    .clk_in(CLK_SYS_IN),
    .reset_n_in(RESET_N_IN),
    .async_in(SER_PIN_IN),
    .sync_out(sync_in)
  );
  stgm_sync2 #(.WIDTH(4), .RESET_VALUE(`STGM_RST_TMR_SYNC)) tmr_sync_u
  (
    .clk_in(CLK_SYS_IN),
    .reset_n_in(RESET_N_IN),
    .async_in(TMR_PIN_IN),
    .sync_out(tsync_in)
  );

  // control registers, one short block each
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      ser_latch_q <= `STGM_RST_SER_LATCH;
    end
    else if (wr_sdat)
    begin
      ser_latch_q <= WDATA_IN;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      ser_dir_q <= `STGM_RST_SER_DIR;
    end
    else if (wr_sdir)
    begin
      ser_dir_q <= WDATA_IN;
    end
  end

  // bits 1 and 4 have no function select
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      ser_func_q <= `STGM_RST_SER_FUNC;
    end
    else if (wr_sfun)
    begin
      ser_func_q <= WDATA_IN & 8'hed;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      tmr_latch_q <= `STGM_RST_TMR_LATCH;
    end
    else if (wr_tdat)
    begin
      tmr_latch_q <= WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      tmr_dir_q <= `STGM_RST_TMR_DIR;
    end
    else if (wr_tdir)
    begin
      tmr_dir_q <= WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      tmr_func_q <= `STGM_RST_TMR_FUNC;
    end
    else if (wr_tfun)
    begin
      tmr_func_q <= WDATA_IN[3:0];
    end
  end

  // kept whole for read-back, though only bits 3 and 4 act
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      ode_q <= `STGM_RST_ODE;
    end
    else if (wr_ode)
    begin
      ode_q <= WDATA_IN;
    end
  end

  // read data stands one cycle, zero otherwise
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  // pin drive from flops, so no glitch reaches a pad
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      ser_out_q <= 8'h00;
      ser_oe_q <= 8'h00;
      tmr_out_q <= 4'h0;
      tmr_oe_q <= 4'h0;
    end
    else
    begin
      ser_out_q <= ser_out_d;
      ser_oe_q <= ser_oe_d;
      tmr_out_q <= tmr_out_d;
      tmr_oe_q <= tmr_oe_d;
    end
  end

  // peripheral side adds one cycle behind the synchroniser
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      side_q <= 10'h000;
    end
    else
    begin
      side_q <= side_d;
    end
  end

  assign RDATA_OUT = rdata_q;
  assign SER_PIN_OUT = ser_out_q;
  assign SER_PIN_OE_OUT = ser_oe_q;
  assign TMR_PIN_OUT = tmr_out_q;
  assign TMR_PIN_OE_OUT = tmr_oe_q;
  assign SERIAL0_RECEIVE_OUT = side_q[0];
  assign SERIAL1_RECEIVE_OUT = side_q[1];
  assign SERIAL0_CLEAR_TO_SEND_OUT = side_q[2];
  assign SERIAL1_CLEAR_TO_SEND_OUT = side_q[3];
  assign TIMER2_CAPTURE_IN0_OUT = side_q[4];
  assign TIMER2_CAPTURE_IN1_OUT = side_q[5];
  assign EXT_IRQ_ONE_OUT = side_q[6];
  assign EXT_IRQ_TWO_OUT = side_q[7];
  assign SLOW_OSC_CONNECT_OUT = side_q[8];
  assign SLOW_OSC_IN_OUT = side_q[9];
endmodule

// two-flop pin synchroniser; reset level matches an idle pulled-up pin
module stgm_sync2
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q, stable_q;

  // only the second stage is read, so a metastable first stage never leaks
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_q <= RESET_VALUE;
      stable_q <= RESET_VALUE;
    end
    else
    begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule
`default_nettype wire

// file: stgm_top_monitor.sv
// assertion checker on the port mux pins and register port
`default_nettype none
module stgm_top_monitor
(
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  // register port
  input wire logic [7:0] ADDR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  // pins and peripheral side
  input wire logic [7:0] SER_PIN_IN,
  input wire logic [7:0] SER_PIN_OUT,
  input wire logic [7:0] SER_PIN_OE_OUT,
  input wire logic SERIAL0_RECEIVE_OUT,
  input wire logic SERIAL1_RECEIVE_OUT,
  input wire logic EXT_IRQ_ONE_OUT,
  input wire logic TIMER2_CAPTURE_IN0_OUT,
  input wire logic SLOW_OSC_CONNECT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  AST_RST_OE: assert property ($rose(RESET_N_IN) |-> SER_PIN_OE_OUT == 8'h00)
    else $error("pin driven at reset release");
  // sync path is several flops deep, so only long-stable levels are compared
  AST_RX: assert property ($stable({SER_PIN_IN[4], SER_PIN_IN[1]})[*5] |->
    {SERIAL1_RECEIVE_OUT, SERIAL0_RECEIVE_OUT} == {SER_PIN_IN[4], SER_PIN_IN[1]})
    else $error("receive path mismatch");
  AST_OD6: assert property (SER_PIN_OE_OUT[6] |-> !SER_PIN_OUT[6])
    else $error("pin 6 driven high");
  AST_OD7: assert property (SER_PIN_OE_OUT[7] |-> !SER_PIN_OUT[7])
    else $error("pin 7 driven high");
  AST_OSC_HIZ: assert property (SLOW_OSC_CONNECT_OUT |-> SER_PIN_OE_OUT[7:6] == 2'b00)
    else $error("oscillator pins driven");
  AST_IRQ: assert property (EXT_IRQ_ONE_OUT == TIMER2_CAPTURE_IN0_OUT)
    else $error("capture and irq differ");
  AST_RD_IDLE: assert property (!$past(RD_IN) |-> RDATA_OUT == 8'h00)
    else $error("read data outside read slot");
  AST_WO_READ: assert property (RD_IN && ADDR_IN inside {8'h26, 8'h27, 8'h2a, 8'h2b} |=>
    RDATA_OUT == 8'h00)
    else $error("write-only register read nonzero");
endmodule
`default_nettype wire

// file: stgm_board_model.sv
// board side: resolves each pin from the mux drive and external drivers, with pull-ups in place of drivers on serial pins 6 and 7
`default_nettype none
module stgm_board_model
(
  // mux drive
  input wire logic [7:0] ser_out_in,
  input wire logic [7:0] ser_oe_in,
  input wire logic [3:0] tmr_out_in,
  input wire logic [3:0] tmr_oe_in,
  // external drivers
  input wire logic [7:0] ser_ext_in,
  input wire logic [3:0] tmr_ext_in,
  // pin levels
  output logic [7:0] ser_pin_out,
  output logic [3:0] tmr_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // upper pins are open drain with pull-ups: released means high
  assign ser_pin_out = (ser_oe_in & ser_out_in) | (~ser_oe_in & {2'b11, ser_ext_in[5:0]});
  assign tmr_pin_out = (tmr_oe_in & tmr_out_in) | (~tmr_oe_in & tmr_ext_in);
endmodule
`default_nettype wire

// file: stgm_top_tb_top.sv
// self-checking bench for the serial/timer port mux
`default_nettype none
module stgm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wr, rd, tx0, tx1, ck0, ck1, cmp0, cmp1;
  logic rx0, rx1, serial0_clear_to_send, serial1_clear_to_send, cap0, cap1, irq1, irq2, osc_c, osc_i;
  logic [7:0] addr, wdata, rdata, ser_in, ser_out, ser_oe, ser_ext, side_w, tmr_w;
  logic [3:0] tmr_in, tmr_out, tmr_oe, tmr_ext;
  int bad_count = 0;
  int n_checks = 0;
  assign side_w = {osc_c, osc_i, serial1_clear_to_send, serial0_clear_to_send, rx1, rx0, 2'h0};
  assign tmr_w = {cap1, cap0, irq2, irq1, tmr_oe};
  stgm_top dut_u (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .SER_PIN_IN(ser_in), .SER_PIN_OUT(ser_out),
    .SER_PIN_OE_OUT(ser_oe), .TMR_PIN_IN(tmr_in), .TMR_PIN_OUT(tmr_out), .TMR_PIN_OE_OUT(tmr_oe),
    .SERIAL0_TRANSMIT_IN(tx0), .SERIAL1_TRANSMIT_IN(tx1), .SERIAL0_CLOCK_PIN_IN(ck0),
    .SERIAL1_CLOCK_PIN_IN(ck1), .SERIAL0_RECEIVE_OUT(rx0), .SERIAL1_RECEIVE_OUT(rx1),
    .SERIAL0_CLEAR_TO_SEND_OUT(serial0_clear_to_send), .SERIAL1_CLEAR_TO_SEND_OUT(serial1_clear_to_send),
    .TIMER2_COMPARE_OUT0_IN(cmp0), .TIMER2_COMPARE_OUT1_IN(cmp1), .TIMER2_CAPTURE_IN0_OUT(cap0),
    .TIMER2_CAPTURE_IN1_OUT(cap1), .EXT_IRQ_ONE_OUT(irq1), .EXT_IRQ_TWO_OUT(irq2),
    .SLOW_OSC_CONNECT_OUT(osc_c), .SLOW_OSC_IN_OUT(osc_i));
  stgm_board_model board_u (.ser_out_in(ser_out), .ser_oe_in(ser_oe), .tmr_out_in(tmr_out),
    .tmr_oe_in(tmr_oe), .ser_ext_in(ser_ext), .tmr_ext_in(tmr_ext), .ser_pin_out(ser_in),
    .tmr_pin_out(tmr_in));
  task automatic give_verdict;
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  // pins lag writes by a cycle and inputs pass a two-flop sync
  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    settle();
    chk("oe", 8'h00, ser_oe);
    chk("side", 8'h0c, side_w);
    chk("tmr", 8'h00, tmr_w);
    rd_chk("ser data", 8'h24, 8'hd2);
    rd_chk("ser dir", 8'h26, 8'h00);
    rd_chk("tmr data", 8'h28, 8'h05);
    rd_chk("unmapped", 8'h30, 8'h00);
  endtask
  task automatic t_tx;
    wr_reg(8'h27, 8'h2d);
    wr_reg(8'h26, 8'h2d);
    settle();
    chk("oe", 8'h2d, ser_oe);
    chk("out", 8'h0c, ser_out & 8'h2d);
    chk("side", 8'hdc, side_w);
    @(posedge clk);
    {tx0, tx1, ck0, ck1} <= 4'b1001;
    settle();
    chk("out", 8'h21, ser_out & 8'h2d);
    chk("side", 8'hec, side_w);
    @(posedge clk);
    {tx0, tx1, ck0, ck1} <= 4'b0110;
    wr_reg(8'h2c, 8'h18);
    settle();
    chk("oe od", 8'h25, ser_oe);
    rd_chk("ode", 8'h2c, 8'h18);
  endtask
  task automatic t_osc;
    wr_reg(8'h2c, 8'h00);
    wr_reg(8'h24, 8'h00);
    wr_reg(8'h26, 8'hc0);
    wr_reg(8'h27, 8'h00);
    settle();
    chk("oe", 8'h00, ser_oe);
    wr_reg(8'h24, 8'h40);
    wr_reg(8'h26, 8'hc0);
    settle();
    chk("oe", 8'h00, ser_oe);
    chk("side", 8'h0c, side_w);
    wr_reg(8'h27, 8'hc0);
    settle();
    chk("oe", 8'h80, ser_oe);
    chk("out", 8'h00, ser_out & 8'hc0);
    rd_chk("ser data", 8'h24, 8'h52);
  endtask
  task automatic t_tmr;
    tmr_ext <= 4'h3;
    wr_reg(8'h2b, 8'h0f);
    wr_reg(8'h2a, 8'h0c);
    settle();
    chk("tmr", 8'hfc, tmr_w);
    chk("tmr out", 8'h04, {4'h0, tmr_out & 4'hc});
    @(posedge clk);
    {cmp0, cmp1} <= 2'b01;
    settle();
    chk("tmr out", 8'h08, {4'h0, tmr_out & 4'hc});
    tmr_ext <= 4'h2;
    settle();
    chk("tmr", 8'hac, tmr_w);
    wr_reg(8'h2a, 8'h0f);
    settle();
    chk("tmr", 8'h0f, tmr_w);
    rd_chk("tmr data", 8'h28, 8'h0f);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial
  begin
    {rst_n, wr, rd, tx0, ck1, cmp1} = '0;
    {tx1, ck0, cmp0} = '1;
    addr = 8'h00;
    wdata = 8'h00;
    ser_ext = 8'h12;
    tmr_ext = 4'h5;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_tx();
    t_osc();
    t_tmr();
    give_verdict();
  end
endmodule
bind stgm_top stgm_top_monitor mon_u (.CLK_SYS_IN, .RESET_N_IN, .ADDR_IN, .RD_IN, .RDATA_OUT,
  .SER_PIN_IN, .SER_PIN_OUT, .SER_PIN_OE_OUT, .SERIAL0_RECEIVE_OUT, .SERIAL1_RECEIVE_OUT,
  .EXT_IRQ_ONE_OUT, .TIMER2_CAPTURE_IN0_OUT, .SLOW_OSC_CONNECT_OUT);
`default_nettype wire
